// [queue_readout_pkg.sv]
package queue_readout_pkg;

	// queue geometry: one word is a tag byte plus six data bytes
	localparam int unsigned     data_bytes        = 6;
	localparam int unsigned     data_width        = 48;
	localparam int unsigned     tag_width         = 8;
	localparam int unsigned     word_width        = 56;
	localparam int unsigned     pointer_width     = 9;
	localparam int unsigned     count_width       = 10;
	localparam logic [9:0]      queue_depth       = 10'h200;
	localparam logic [9:0]      almost_full_level = 10'h1ff;

	// tag byte layout
	localparam int unsigned     source_id_width   = 5;
	localparam int unsigned     source_id_lsb     = 3;
	localparam int unsigned     slot_lsb          = 1;
	localparam int unsigned     parity_bit        = 0;

	// source identifiers carried in the tag
	localparam logic [4:0]      source_gyroscope     = 5'h01;
	localparam logic [4:0]      source_accelerometer = 5'h02;
	localparam logic [4:0]      source_temperature   = 5'h03;
	localparam logic [4:0]      source_timestamp     = 5'h04;
	localparam logic [4:0]      source_config_change = 5'h05;
	localparam logic [4:0]      source_hub_sensor_0  = 5'h0e;
	localparam logic [4:0]      source_hub_sensor_1  = 5'h0f;
	localparam logic [4:0]      source_hub_sensor_2  = 5'h10;
	localparam logic [4:0]      source_hub_sensor_3  = 5'h11;
	localparam logic [4:0]      source_hub_nack      = 5'h19;

	// register addresses
	localparam logic [7:0]      queue_level_low_offset        = 8'h1a;
	localparam logic [7:0]      queue_flags_level_high_offset = 8'h1b;
	localparam logic [7:0]      queue_word_tag_offset         = 8'h78;
	localparam logic [7:0]      queue_read_x_low_offset       = 8'h79;
	localparam logic [7:0]      queue_read_z_high_offset      = 8'h7e;

	// second status register bit positions
	localparam int unsigned     level_flag_bit     = 7;
	localparam int unsigned     overwrite_flag_bit = 6;
	localparam int unsigned     full_flag_bit      = 5;
	localparam int unsigned     batch_flag_bit     = 4;
	localparam int unsigned     sticky_flag_bit    = 3;

	// reset values and widths of the batch counter, slot counter, byte tracker and read data
	localparam int unsigned     batch_count_width  = 11;
	localparam logic [10:0]     batch_count_reset  = 11'h000;
	localparam logic [1:0]      slot_counter_reset = 2'h0;
	localparam logic [6:0]      bytes_read_none    = 7'h00;
	localparam logic [6:0]      bytes_read_all     = 7'h7f;
	localparam logic [7:0]      read_data_reset    = 8'h00;

endpackage

// [queue_word_memory.sv]
`timescale 1ns/1ps

module queue_word_memory (
	// clock and reset
	input  wire logic                                        clock,
	input  wire logic                                        reset_n,
	// write port
	input  wire logic                                        write_enable,
	input  wire logic [queue_readout_pkg::pointer_width-1:0] write_address,
	input  wire logic [queue_readout_pkg::word_width-1:0]    write_data,
	// read port, registered
	input  wire logic [queue_readout_pkg::pointer_width-1:0] read_address,
	output logic      [queue_readout_pkg::word_width-1:0]    read_data
);
	import queue_readout_pkg::*;

	logic [word_width-1:0] storage [0:(1 << pointer_width)-1];

	// array carries no reset; only the read register does
	always_ff @(posedge clock) begin
		if (write_enable) begin
			storage[write_address] <= write_data;
		end
	end

	// write-first bypass so a word pushed into an empty queue is visible at once
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_data <= '0;
		end else if (write_enable && (write_address == read_address)) begin
			read_data <= write_data;
		end else begin
			read_data <= storage[read_address];
		end
	end

endmodule

// [fifo_status_and_tagged_readout.sv]
`timescale 1ns/1ps

// Summary of operation
// RL1: ten-bit unread word count across both status
// RL2: level flag high when count reaches watermark
// RL3: four flags routable to either interrupt pin
// RL4: overwrite flag on overrun, cleared by pop
// RL5: full flag when next write fills queue
// RL6: batch flag on threshold, cleared reading status2
// RL7: sticky overwrite flag cleared only reading status2
// RL8: status follows every queue write and read
// RL9: block update keeps status pair coherent, status1 first
// RL10: tag holds source, slot counter, parity
// RL11: main and auxiliary source codes one to five
// RL12: hub sensors 0e to 11, nack 19
// RL13: tag parity makes ones count even
// RL14: six data bytes at 79h to 7eh
// RL15: data meaning follows the word's source code
// RL16: slot counter wraps on each main batch event
// RL17: tag byte sits at 78h before data
// RL18: nine-bit watermark in words compared with count
// RL19: word popped once tag and six bytes read
module fifo_status_and_tagged_readout (
	// clock and reset
	input  wire logic                                          clock,
	input  wire logic                                          reset_n,
	// queue write side
	input  wire logic                                          push_valid,
	input  wire logic [queue_readout_pkg::source_id_width-1:0] push_source_id,
	input  wire logic [queue_readout_pkg::data_width-1:0]      push_data,
	// batch events
	input  wire logic                                          main_batch_event,
	input  wire logic                                          accel_batch_event,
	input  wire logic                                          gyro_batch_event,
	// queue configuration
	input  wire logic [8:0]                                    watermark_threshold,
	input  wire logic [10:0]                                   batch_count_threshold,
	input  wire logic                                          batch_trigger_gyro,
	input  wire logic                                          batch_counter_clear,
	input  wire logic                                          block_data_update,
	// pin routing
	input  wire logic                                          pin1_level_route,
	input  wire logic                                          pin1_overwrite_route,
	input  wire logic                                          pin1_full_route,
	input  wire logic                                          pin1_batch_count_route,
	input  wire logic                                          pin2_level_route,
	input  wire logic                                          pin2_overwrite_route,
	input  wire logic                                          pin2_full_route,
	input  wire logic                                          pin2_batch_count_route,
	// register read port
	input  wire logic                                          reg_read,
	input  wire logic [7:0]                                    reg_addr,
	output logic      [7:0]                                    reg_rdata,
	output logic                                               reg_rdata_valid,
	// interrupt pins
	output logic                                               int1_pin,
	output logic                                               int2_pin
);
	import queue_readout_pkg::*;

	// queue state
	logic [pointer_width-1:0]     write_pointer;
	logic [pointer_width-1:0]     read_pointer;
	logic [pointer_width-1:0]     next_read_pointer;
	logic [count_width-1:0]       queue_word_count;
	logic [word_width-1:0]        head_word;
	logic [6:0]                   bytes_read;
	logic [6:0]                   next_bytes_read;
	logic [1:0]                   slot_counter;
	logic [batch_count_width-1:0] batch_counter;

	// flags held in flip-flops
	logic                         overwrite_flag;
	logic                         overwrite_sticky_flag;
	logic                         batch_count_hit_flag;

	// flags derived from the count
	logic                         level_threshold_flag;
	logic                         queue_full_flag;

	// coherent snapshot of the second status register
	logic [7:0]                   held_status2;
	logic                         held_valid;

	// decoded events
	logic                         queue_empty;
	logic                         queue_byte_read;
	logic [2:0]                   tag_byte_index;
	logic                         pop;
	logic                         overrun;
	logic                         batch_trigger;
	logic                         batch_hit;
	logic                         status1_read;
	logic                         status2_read;
	logic [7:0]                   live_status2;
	logic [tag_width-1:0]         push_tag;
	logic [7:0]                   byte_mux;

	// read decode of the seven queue word bytes
	assign queue_empty     = (queue_word_count == '0);
	assign queue_byte_read = reg_read && (reg_addr >= queue_word_tag_offset)
		&& (reg_addr <= queue_read_z_high_offset);                       // RL17 RL14
	assign tag_byte_index  = 3'(reg_addr - queue_word_tag_offset);
	assign status1_read    = reg_read && (reg_addr == queue_level_low_offset);
	assign status2_read    = reg_read && (reg_addr == queue_flags_level_high_offset);

	// track which bytes of the head word the host has already taken
	always_comb begin
		next_bytes_read = bytes_read;
		if (queue_byte_read) begin
			next_bytes_read = bytes_read | (7'h01 << tag_byte_index);
		end
	end

	// pop only once the whole word is out; partial reads leave it in place
	assign pop     = !queue_empty && (next_bytes_read == bytes_read_all);      // RL19
	// a push into a full queue that is not draining drops the oldest word
	assign overrun = push_valid && !pop && (queue_word_count == queue_depth);   // RL4

	// tag assembly: even parity over the whole byte
	assign push_tag = {push_source_id, slot_counter,
		^{push_source_id, slot_counter}};                                   // RL10 RL13 RL11 RL12

	// write pointer advances on every push, overrun or not
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			write_pointer <= '0;
		end else if (push_valid) begin
			write_pointer <= write_pointer + 1'b1;
		end
	end

	// read pointer steps on a pop or when an overrun discards the oldest word
	assign next_read_pointer = (pop || overrun) ? read_pointer + 1'b1 : read_pointer;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_pointer <= '0;
		end else begin
			read_pointer <= next_read_pointer;                                 // RL19
		end
	end

	// unread count follows writes and reads in the same cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			queue_word_count <= '0;
		end else if (push_valid && !pop && (queue_word_count != queue_depth)) begin
			queue_word_count <= queue_word_count + 1'b1;                       // RL8 RL1
		end else if (pop && !push_valid) begin
			queue_word_count <= queue_word_count - 1'b1;                       // RL8 RL19
		end
	end

	// progress through the head word restarts whenever the head changes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bytes_read <= bytes_read_none;
		end else if (pop || overrun || queue_empty) begin
			bytes_read <= bytes_read_none;
		end else begin
			bytes_read <= next_bytes_read;
		end
	end

	// word store; read address looks ahead so the head is current after a pop
	queue_word_memory word_store (
		.clock         (clock),
		.reset_n       (reset_n),
		.write_enable  (push_valid),
		.write_address (write_pointer),
		.write_data    ({push_tag, push_data}),
		.read_address  (next_read_pointer),
		.read_data     (head_word)
	);

	// slot counter wraps 3 to 0 on each batch event of the fastest main sensor
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			slot_counter <= slot_counter_reset;
		end else if (main_batch_event) begin
			slot_counter <= slot_counter + 1'b1;                               // RL16
		end
	end

	// level and full indications come straight from the live count
	assign level_threshold_flag = (queue_word_count >= {1'b0, watermark_threshold}); // RL2 RL18
	assign queue_full_flag      = (queue_word_count >= almost_full_level);           // RL5

	// overwrite flag: a push into a full queue in the same cycle as a pop does not set it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			overwrite_flag <= 1'b0;
		end else if (overrun) begin
			overwrite_flag <= 1'b1;                                            // RL4
		end else if (pop) begin
			overwrite_flag <= 1'b0;                                            // RL4
		end
	end

	// sticky overwrite flag survives reads of the data, only status2 clears it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			overwrite_sticky_flag <= 1'b0;
		end else if (overrun) begin
			overwrite_sticky_flag <= 1'b1;                                     // RL7
		end else if (status2_read) begin
			overwrite_sticky_flag <= 1'b0;                                     // RL7
		end
	end

	// batch counter restarts after each hit so the flag repeats every threshold samples
	assign batch_trigger = batch_trigger_gyro ? gyro_batch_event : accel_batch_event;
	assign batch_hit     = batch_trigger && (batch_count_threshold != batch_count_reset)
		&& ((batch_counter + 1'b1) >= batch_count_threshold);                  // RL6

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			batch_counter <= batch_count_reset;
		end else if (batch_counter_clear || batch_hit) begin
			batch_counter <= batch_count_reset;
		end else if (batch_trigger) begin
			batch_counter <= batch_counter + 1'b1;
		end
	end

	// batch flag: a hit in the clearing read cycle wins over the clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			batch_count_hit_flag <= 1'b0;
		end else if (batch_hit) begin
			batch_count_hit_flag <= 1'b1;                                      // RL6
		end else if (status2_read) begin
			batch_count_hit_flag <= 1'b0;                                      // RL6
		end
	end

	// second status register as the hardware sees it now
	always_comb begin
		live_status2                     = 8'h00;
		live_status2[level_flag_bit]     = level_threshold_flag;
		live_status2[overwrite_flag_bit] = overwrite_flag;
		live_status2[full_flag_bit]      = queue_full_flag;
		live_status2[batch_flag_bit]     = batch_count_hit_flag;
		live_status2[sticky_flag_bit]    = overwrite_sticky_flag;
		live_status2[1:0]                = queue_word_count[9:8];             // RL1
	end

	// with block update on, reading status1 freezes status2 until it is read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			held_status2 <= 8'h00;
			held_valid   <= 1'b0;
		end else if (block_data_update && status1_read) begin
			held_status2 <= live_status2;                                      // RL9
			held_valid   <= 1'b1;
		end else if (status2_read || !block_data_update) begin
			held_valid   <= 1'b0;
		end
	end

	// read data select; an empty queue reads as zero rather than stale words
	always_comb begin
		byte_mux = read_data_reset;
		if (queue_byte_read && !queue_empty) begin
			if (tag_byte_index == 3'h0) begin
				byte_mux = head_word[word_width-1 -: tag_width];               // RL17
			end else begin
				byte_mux = head_word[8*(tag_byte_index - 3'h1) +: 8];          // RL14 RL15
			end
		end else if (status1_read) begin
			byte_mux = queue_word_count[7:0];                                  // RL1
		end else if (status2_read) begin
			byte_mux = (block_data_update && held_valid) ? held_status2 : live_status2; // RL9
		end
	end

	// answer one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata       <= read_data_reset;
			reg_rdata_valid <= 1'b0;
		end else begin
			reg_rdata       <= byte_mux;
			reg_rdata_valid <= reg_read;
		end
	end

	// pin routing; registered so the pins never glitch on count changes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			int1_pin <= 1'b0;
			int2_pin <= 1'b0;
		end else begin
			int1_pin <= (pin1_level_route && level_threshold_flag)
				|| (pin1_overwrite_route && overwrite_flag)
				|| (pin1_full_route && queue_full_flag)
				|| (pin1_batch_count_route && batch_count_hit_flag);           // RL3
			int2_pin <= (pin2_level_route && level_threshold_flag)
				|| (pin2_overwrite_route && overwrite_flag)
				|| (pin2_full_route && queue_full_flag)
				|| (pin2_batch_count_route && batch_count_hit_flag);           // RL3
		end
	end

endmodule

// [fifo_readout_monitor.sv]
`timescale 1ns/1ps
module fifo_readout_monitor (
	// clock and reset
	input wire logic       clock,
	input wire logic       reset_n,
	// queue and batch inputs
	input wire logic       push_valid,
	input wire logic       accel_batch_event,
	input wire logic       gyro_batch_event,
	input wire logic [8:0] watermark_threshold,
	// pin routing
	input wire logic       pin1_level_route,
	input wire logic       pin1_overwrite_route,
	input wire logic       pin1_full_route,
	input wire logic       pin1_batch_count_route,
	input wire logic       pin2_level_route,
	input wire logic       pin2_overwrite_route,
	input wire logic       pin2_full_route,
	input wire logic       pin2_batch_count_route,
	// register port and pins
	input wire logic       reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rdata_valid,
	input wire logic       int1_pin,
	input wire logic       int2_pin
);
	logic pin1_any;
	logic pin2_any;

	// a pin with no route at all must stay low whatever the flags do
	assign pin1_any = pin1_level_route | pin1_overwrite_route | pin1_full_route | pin1_batch_count_route;
	assign pin2_any = pin2_level_route | pin2_overwrite_route | pin2_full_route | pin2_batch_count_route;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// status2 read while nothing can set the self-clearing bits
	sequence s_quiet_status2;
		reg_read && reg_addr == 8'h1b && !push_valid && !accel_batch_event && !gyro_batch_event;
	endsequence
	// status1 read with no push landing
	sequence s_still_status1;
		reg_read && reg_addr == 8'h1a && !push_valid;
	endsequence

	read_answer_a: assert property (reg_read |=> reg_rdata_valid)
		else $error("read strobe not answered next cycle");
	quiet_valid_a: assert property (!reg_read |=> !reg_rdata_valid)
		else $error("answer without a read strobe");
	level_pin_a: assert property ((watermark_threshold == 9'h000 && pin1_level_route) [*2] |=> int1_pin)
		else $error("level flag not on pin 1 at zero threshold");
	pin1_silent_a: assert property (!pin1_any [*2] |-> !int1_pin)
		else $error("pin 1 high with no route");
	pin2_silent_a: assert property (!pin2_any && $past(!pin2_any) |-> !int2_pin)
		else $error("pin 2 high with no route");
	status_spare_a: assert property (reg_read && reg_addr == 8'h1b |=> reg_rdata[2] == 1'b0)
		else $error("status2 bit 2 not zero");
	tag_parity_a: assert property (reg_read && reg_addr == 8'h78 |=> !(^reg_rdata))
		else $error("tag byte has odd parity");
	sticky_clear_a: assert property (s_quiet_status2 ##1 s_quiet_status2 |=> reg_rdata[4:3] == 2'b00)
		else $error("status2 read did not clear batch or sticky bit");
	count_stable_a: assert property (s_still_status1 ##1 reg_read && reg_addr == 8'h1a |=> $stable(reg_rdata))
		else $error("count moved with no queue traffic");
	full_coherent_a: assert property (reg_read && reg_addr == 8'h1b |=>
		(!reg_rdata[1] || reg_rdata[5]) && (!reg_rdata[6] || reg_rdata[1]) && (!reg_rdata[5] || reg_rdata[1:0] != 2'b00))
		else $error("full or overwrite flag disagrees with count");
endmodule

bind fifo_status_and_tagged_readout fifo_readout_monitor i_monitor (.*);

// [host_reader.sv]
`timescale 1ns/1ps
module host_reader (
	// clock
	input wire logic       clock,
	// register port of the device
	output logic           reg_read,
	output logic     [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rdata_valid,
	// tag check result
	output logic           tag_corrupt
);
	logic tag_pending;

	initial begin
		reg_read = 1'b0;
		reg_addr = 8'h00;
		tag_corrupt = 1'b0;
	end

	// one strobe per call, so consecutive calls read back to back
	task automatic rd(input logic [7:0] addr);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= addr;
	endtask

	// idle cycles scramble the address so nothing leans on a stale value
	task automatic idle(input int cycles);
		repeat (cycles) begin
			@(posedge clock);
			reg_read <= 1'b0;
			reg_addr <= ~reg_addr;
		end
	endtask

	// a tag with an odd count of ones is taken as corrupted
	always @(posedge clock) begin
		tag_pending <= reg_read && reg_addr == 8'h78;
		if (tag_pending && reg_rdata_valid && ^reg_rdata) begin
			tag_corrupt <= 1'b1;
		end
	end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic        clock;
	logic        reset_n;
	logic        push_valid;
	logic [4:0]  push_source_id;
	logic [47:0] push_data;
	logic        main_batch_event;
	logic        accel_batch_event;
	logic        gyro_batch_event;
	logic [8:0]  watermark_threshold;
	logic [10:0] batch_count_threshold;
	logic        batch_trigger_gyro;
	logic        batch_counter_clear;
	logic        block_data_update;
	logic [3:0]  route1;
	logic [3:0]  route2;
	logic        reg_read;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_rdata;
	logic        reg_rdata_valid;
	logic        int1_pin;
	logic        int2_pin;
	logic        tag_corrupt;
	int          n_mismatch;
	int          compares;
	logic        ovr;
	logic        sticky;
	logic        batch;
	logic [1:0]  slot;
	logic [7:0]  st;
	logic [7:0]  exp_q[$];
	logic [55:0] model_q[$];
	logic [4:0]  sources[10];
	logic [2:0]  pattern[5];

	// route bits: 0 level, 1 overwrite, 2 full, 3 batch count
	fifo_status_and_tagged_readout i_dut (
		.clock(clock), .reset_n(reset_n), .push_valid(push_valid), .push_source_id(push_source_id),
		.push_data(push_data), .main_batch_event(main_batch_event), .accel_batch_event(accel_batch_event),
		.gyro_batch_event(gyro_batch_event), .watermark_threshold(watermark_threshold),
		.batch_count_threshold(batch_count_threshold), .batch_trigger_gyro(batch_trigger_gyro),
		.batch_counter_clear(batch_counter_clear), .block_data_update(block_data_update),
		.pin1_level_route(route1[0]), .pin1_overwrite_route(route1[1]), .pin1_full_route(route1[2]),
		.pin1_batch_count_route(route1[3]), .pin2_level_route(route2[0]), .pin2_overwrite_route(route2[1]),
		.pin2_full_route(route2[2]), .pin2_batch_count_route(route2[3]), .reg_read(reg_read),
		.reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
		.int1_pin(int1_pin), .int2_pin(int2_pin));

	host_reader i_host (.clock(clock), .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
		.reg_rdata_valid(reg_rdata_valid), .tag_corrupt(tag_corrupt));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		compares++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic pins(input logic e1, input logic e2);
		check({6'h00, int1_pin, int2_pin}, {6'h00, e1, e2});
	endtask

	task automatic complete_run();
		// a read that never came back is as bad as a wrong byte
		if (exp_q.size() != 0) begin
			n_mismatch++;
			$display("Error at %0t: %0d reads never answered", $time, exp_q.size());
		end
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// note the expected byte, then let the host strobe the read
	task automatic read_exp(input logic [7:0] addr, input logic [7:0] expv);
		exp_q.push_back(expv);
		i_host.rd(addr);
	endtask

	function automatic logic [7:0] stat2();
		logic [9:0] n;
		n = 10'(model_q.size());
		return {n >= {1'b0, watermark_threshold}, ovr, n >= 10'h1ff, batch, sticky, 1'b0, n[9:8]};
	endfunction

	// status1 always first so the pair stays coherent
	task automatic rd_status();
		read_exp(8'h1a, 8'(model_q.size()));
		read_exp(8'h1b, stat2());
		batch = 1'b0;
		sticky = 1'b0;
	endtask

	// push one word; the model drops its oldest word on overrun
	task automatic push(input logic [4:0] src);
		logic [7:0]  tag;
		logic [47:0] d;
		d = 48'({$urandom(), $urandom()});
		tag = {src, slot, ^{src, slot}};
		@(posedge clock);
		push_valid <= 1'b1;
		push_source_id <= src;
		push_data <= d;
		main_batch_event <= 1'b1;
		if (model_q.size() == 512)
			void'(model_q.pop_front());
		model_q.push_back({d, tag});
		slot = slot + 2'h1;
	endtask

	task automatic quiet();
		@(posedge clock);
		push_valid <= 1'b0;
		main_batch_event <= 1'b0;
	endtask

	// tag then six data bytes; the word leaves once all seven are read
	task automatic rd_word();
		logic [55:0] w;
		w = model_q.pop_front();
		for (int i = 0; i < 7; i++)
			read_exp(8'h78 + 8'(i), w[8*i +: 8]);
		ovr = 1'b0;
	endtask

	// answers are matched oldest first as they appear
	always @(posedge clock) begin
		if (reg_rdata_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("Error at %0t: answer with no expected byte", $time);
			end else
				check(reg_rdata, exp_q.pop_front());
		end
	end

	// the run needs about seven hundred cycles; far beyond that it has hung
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end

	initial begin
		{push_valid, main_batch_event, accel_batch_event, gyro_batch_event, batch_trigger_gyro,
			batch_counter_clear, block_data_update, route1, route2, push_source_id, push_data} = '0;
		watermark_threshold = 9'h00a;
		batch_count_threshold = 11'h003;
		{n_mismatch, compares, ovr, sticky, batch, slot} = '0;
		sources = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h19};
		pattern = '{3'b110, 3'b010, 3'b001, 3'b010, 3'b000};
		reset_n = 1'b0;
		void'($urandom(32'hcbe14ce0));
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		route2 <= 4'b0001;
		foreach (sources[i]) push(sources[i]);
		quiet();
		read_exp(8'h1a, 8'h0a);
		rd_status();
		i_host.idle(3);
		pins(1'b0, 1'b1);
		repeat (10) rd_word();
		i_host.idle(3);
		pins(1'b0, 1'b0);
		$display("test tags done");
		read_exp(8'h77, 8'h00);
		read_exp(8'h7f, 8'h00);
		read_exp(8'h78, 8'h00);
		read_exp(8'h20 + 8'($urandom_range(87)), 8'h00);
		rd_status();
		i_host.idle(1);
		watermark_threshold <= 9'h000;
		route1 <= 4'b0001;
		i_host.idle(3);
		pins(1'b1, 1'b1);
		watermark_threshold <= 9'h00a;
		route1 <= 4'b1000;
		$display("test empty done");
		batch_trigger_gyro <= 1'b1;
		batch_count_threshold <= 11'(3 + $urandom_range(4));
		foreach (pattern[i]) begin
			@(posedge clock);
			{batch_counter_clear, gyro_batch_event, accel_batch_event} <= pattern[i];
		end
		rd_status();
		i_host.idle(1);
		// the pattern left two counted events, so the hit needs threshold minus two more
		gyro_batch_event <= 1'b1;
		repeat (batch_count_threshold - 11'h002) @(posedge clock);
		gyro_batch_event <= 1'b0;
		batch = 1'b1;
		i_host.idle(3);
		pins(1'b1, 1'b0);
		rd_status();
		read_exp(8'h1b, stat2());
		i_host.idle(3);
		pins(1'b0, 1'b0);
		$display("test batch done");
		watermark_threshold <= 9'h100;
		route1 <= 4'b0100;
		route2 <= 4'b0010;
		block_data_update <= 1'b1;
		repeat (512) push(sources[$urandom_range(9)]);
		quiet();
		i_host.idle(3);
		pins(1'b1, 1'b0);
		rd_status();
		i_host.idle(1);
		push(sources[1]);
		quiet();
		{ovr, sticky} = 2'b11;
		i_host.idle(3);
		pins(1'b1, 1'b1);
		// random routes and watermark while overwrite, full and level flags all stand
		repeat (4) begin
			{route1, route2} <= 8'($urandom());
			watermark_threshold <= 9'($urandom());
			i_host.idle(3);
			st = stat2();
			pins(|(route1 & {st[4], st[5], st[6], st[7]}), |(route2 & {st[4], st[5], st[6], st[7]}));
		end
		route1 <= 4'b0100;
		route2 <= 4'b0010;
		rd_status();
		read_exp(8'h1b, stat2());
		rd_word();
		i_host.idle(3);
		pins(1'b1, 1'b0);
		rd_status();
		i_host.idle(4);
		check({7'h00, tag_corrupt}, 8'h00);
		$display("test overrun done");
		complete_run();
	end
endmodule
